// File: core/swcfg_suspend_wake.v
// Our own choices: the register offsets and strobed register access.
`timescale 1ns/1ps
`include "swcfg_map.vh"
module swcfg_suspend_wake #(
  parameter        WAKE_CYCLES = `SWCFG_WAKE_CYCLES,
  parameter [15:0] VENDOR_CODE = 16'h0ABC  // Arbitrary value
) (
  input  wire        clk,
  input  wire        rst_b,
  input  wire [7:0]  regAddr,
  input  wire [15:0] regWrData,
  input  wire        regWr,
  input  wire        regRd,
  output reg  [15:0] regRdData,
  input  wire        rxAvailNIn,
  input  wire        rxAvailNFifo,
  output wire        rxAvailNOut,
  output wire        rxAvailNOe,
  output wire        fifoPullDown,
  output reg         power_enable_n,
  output reg         enumReady,
  output reg         remoteWake
);
  localparam [1:0] ST_LOAD = 2'd0;
  localparam [1:0] ST_WAIT = 2'd1;
  localparam [1:0] ST_RUN  = 2'd2;

  // Loader sequencing; the capture side trails the store address by one cycle
  reg  [1:0]  state;
  reg  [5:0]  loadIdx;
  reg         capValid;
  reg  [5:0]  capIdx;

  // Latched copies of the store words; they keep their values over a USB reset
  reg  [15:0] options;
  reg  [15:0] maxPower;
  reg  [15:0] usbVersion;
  reg  [15:0] serialNum;

  // Bus state as reported by the USB engine
  reg         configured;
  reg         suspended;
  reg         usbResetReq;

  // Resume timer; 32 bits cover the full 20 ms count at any sane clock
  reg  [31:0] wakeCnt;
  wire [15:0] storeData;
  wire        ctrlWr;
  wire        wakeLast;

  // True when the wake input is live (suspended and option set)
  function wakeSense;
    input susp;
    input [15:0] opt;
    begin
      wakeSense = susp & opt[`SWCFG_OPT_WAKEEN];
    end
  endfunction

  // True for a write strobe aimed at the control register
  function ctrlWrite;
    input       wr;
    input [7:0] addr;
    begin
      ctrlWrite = wr & (addr == `SWCFG_REG_CTRL);
    end
  endfunction

  // Shared decodes: the control write feeds three registers, the last resume
  // cycle both ends the pulse and releases suspend, so they must agree
  assign ctrlWr   = ctrlWrite(regWr, regAddr);
  assign wakeLast = remoteWake & (wakeCnt == 32'd1);

  swcfg_store u_store (
    .clk    (clk),
    .rst_b  (rst_b),
    .rdAddr (loadIdx),
    .rdData (storeData)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Configuration loader; restarts on any reset, though after a USB reset the old options stay in force until reloaded
  always @(posedge clk) begin
    if (!rst_b) begin
      state      <= ST_LOAD;
      loadIdx    <= 6'h00;
      capValid   <= 1'b0;
      capIdx     <= 6'h00;
      options    <= 16'h0000;
      maxPower   <= 16'h0000;
      usbVersion <= 16'h0000;
      serialNum  <= 16'h0000;
      enumReady  <= 1'b0;
    end else if (usbResetReq) begin
      state     <= ST_LOAD;
      loadIdx   <= 6'h00;
      capValid  <= 1'b0;
      enumReady <= 1'b0;
    end else begin
      capValid <= 1'b0;
      capIdx   <= loadIdx;
      case (state)
        ST_LOAD: begin
          capValid <= 1'b1;
          if (loadIdx == `SWCFG_LOAD_WORDS - 1) begin
            state <= ST_WAIT;
          end else begin
            loadIdx <= loadIdx + 6'h01;
          end
        end
        ST_WAIT: begin
          state     <= ST_RUN;
          enumReady <= 1'b1;
        end
        ST_RUN: begin
          enumReady <= 1'b1;
        end
        default: begin
          state <= ST_LOAD;
        end
      endcase
      if (capValid) begin
        case (capIdx)
          `SWCFG_ADDR_OPTIONS:  options    <= storeData;
          `SWCFG_ADDR_MAXPOWER: maxPower   <= storeData;
          `SWCFG_ADDR_USBVER:   usbVersion <= storeData;
          `SWCFG_ADDR_SERIAL:   serialNum  <= storeData;
          default: ;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus state from the USB engine, written by software
  always @(posedge clk) begin
    if (!rst_b) begin
      configured  <= 1'b0;
      suspended   <= 1'b0;
      usbResetReq <= 1'b0;
    end else begin
      usbResetReq <= ctrlWr & regWrData[`SWCFG_CTRL_USBRST];
      if (ctrlWr) begin
        // A reload about to start refuses configuration even if the old
        // load still shows ready; the host must enumerate again first
        configured <= regWrData[`SWCFG_CTRL_CONFIG] & enumReady & ~usbResetReq;
        suspended  <= regWrData[`SWCFG_CTRL_SUSPEND];
      end else if (usbResetReq) begin
        configured <= 1'b0;  // Reset deconfigures the device
        suspended  <= 1'b0;
      end else if (wakeLast) begin
        suspended <= 1'b0;  // Host resumed after the wake signal
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Power enable: low only when configured and awake
  // Registered so the external power switch never sees a decode glitch
  always @(posedge clk) begin
    if (!rst_b) begin
      power_enable_n <= 1'b1;
    end else begin
      power_enable_n <= ~(configured & ~suspended);
    end
  end

  // Pull-down and pin direction during suspend
  // Combinational so the pins follow suspend without an extra cycle of drive
  assign fifoPullDown = suspended & options[`SWCFG_OPT_PULLDN];
  assign rxAvailNOe   = ~wakeSense(suspended, options);
  assign rxAvailNOut  = rxAvailNFifo;  // Flag comes from the FIFO

  ////////////////////////////////////////////////////////////////////////////
  // Remote wake: a low level starts a fixed-length resume signal
  always @(posedge clk) begin
    if (!rst_b) begin
      remoteWake <= 1'b0;
      wakeCnt    <= 32'd0;
    end else if (remoteWake) begin
      wakeCnt <= wakeCnt - 32'd1;
      // Strobes seen while the pulse runs are dropped: one request, one resume
      if (wakeLast) begin
        remoteWake <= 1'b0;
      end
    end else if (wakeSense(suspended, options) && !rxAvailNIn) begin
      remoteWake <= 1'b1;
      wakeCnt    <= WAKE_CYCLES;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register read port, data in the following cycle; unmapped reads zero
  // Reads have no side effects, so software may poll status freely
  always @(posedge clk) begin
    if (!rst_b) begin
      regRdData <= 16'h0000;
    end else if (regRd) begin
      case (regAddr)
        `SWCFG_REG_CTRL:     regRdData <= {13'h0000, suspended, configured, 1'b0};
        `SWCFG_REG_STATUS:   regRdData <= {10'h000, options[`SWCFG_OPT_SERIALEN],
                                           options[`SWCFG_OPT_WAKEEN], fifoPullDown,
                                           remoteWake, power_enable_n, enumReady};
        `SWCFG_REG_MAXPOWER: regRdData <= maxPower;
        `SWCFG_REG_USBVER:   regRdData <= usbVersion;
        `SWCFG_REG_SERIAL:   regRdData <= options[`SWCFG_OPT_SERIALEN] ?
                                          serialNum : 16'h0000;
        `SWCFG_REG_VENDOR:   regRdData <= VENDOR_CODE;
        default:             regRdData <= 16'h0000;
      endcase
    end else begin
      regRdData <= 16'h0000;
    end
  end
endmodule // swcfg_suspend_wake

// File: include/swcfg_map.vh
`ifndef SWCFG_MAP_VH
`define SWCFG_MAP_VH
// Register offsets (8-bit index on the plain port)
`define SWCFG_REG_CTRL      8'h00
`define SWCFG_REG_STATUS    8'h01
`define SWCFG_REG_MAXPOWER  8'h02
`define SWCFG_REG_USBVER    8'h03
`define SWCFG_REG_SERIAL    8'h04
`define SWCFG_REG_VENDOR    8'h05
// Control register fields
`define SWCFG_CTRL_USBRST   0
`define SWCFG_CTRL_CONFIG   1
`define SWCFG_CTRL_SUSPEND  2
// Status register fields
`define SWCFG_ST_LOADED     0
`define SWCFG_ST_POWER_ENABLE_N_N    1
`define SWCFG_ST_WAKE       2
`define SWCFG_ST_PULLDN     3
`define SWCFG_ST_WAKEEN     4
`define SWCFG_ST_SERIALEN   5
// Configuration store layout
`define SWCFG_ADDR_OPTIONS  6'h00
`define SWCFG_ADDR_MAXPOWER 6'h01
`define SWCFG_ADDR_USBVER   6'h02
`define SWCFG_ADDR_SERIAL   6'h03
`define SWCFG_OPT_PULLDN    0
`define SWCFG_OPT_WAKEEN    1
`define SWCFG_OPT_SERIALEN  2
`define SWCFG_LOAD_WORDS    4
// Defaults of the store
`define SWCFG_DEF_OPTIONS   16'h0006
`define SWCFG_DEF_MAXPOWER  16'h005A
`define SWCFG_DEF_USBVER    16'h0200
`define SWCFG_DEF_SERIAL    16'h1234
// Timing
`define SWCFG_CLK_HZ        20000000
`define SWCFG_WAKE_MS       20
`define SWCFG_WAKE_CYCLES   ((`SWCFG_CLK_HZ / 1000) * `SWCFG_WAKE_MS)
`endif

// File: core/swcfg_store.v
`timescale 1ns/1ps
`include "swcfg_map.vh"
// Nonvolatile configuration store, modelled as flip-flops with one-cycle read
module swcfg_store #(
  parameter [15:0] SERIAL = `SWCFG_DEF_SERIAL
) (
  input  wire        clk,
  input  wire        rst_b,
  input  wire [5:0]  rdAddr,
  output reg  [15:0] rdData
);
  reg [15:0] mem [0:`SWCFG_LOAD_WORDS-1];

  // Contents survive reset; only the read port is reset
  always @(posedge clk) begin
    mem[0] <= `SWCFG_DEF_OPTIONS;
    mem[1] <= `SWCFG_DEF_MAXPOWER;
    mem[2] <= `SWCFG_DEF_USBVER;
    mem[3] <= SERIAL;
    if (!rst_b) begin
      rdData <= 16'h0000;
    end else begin
      rdData <= mem[rdAddr[1:0]];
    end
  end
endmodule // swcfg_store

// File: verif/swcfg_monitor.sv
`timescale 1ns/1ps
`include "swcfg_map.vh"
// Port-level checks of the suspend and wake logic
module swcfg_monitor #(
  parameter WAKE_CYCLES = `SWCFG_WAKE_CYCLES
) (
  input wire        clk,
  input wire        rst_b,
  input wire [7:0]  regAddr,
  input wire [15:0] regWrData,
  input wire        regWr,
  input wire        regRd,
  input wire [15:0] regRdData,
  input wire        rxAvailNIn,
  input wire        rxAvailNOe,
  input wire        fifoPullDown,
  input wire        power_enable_n,
  input wire        enumReady,
  input wire        remoteWake
);
  integer wakeCnt;
  // Resume pulse length; a counter because the count is a parameter
  always @(posedge clk) wakeCnt <= (!rst_b || !remoteWake) ? 0 : wakeCnt + 1;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  ////////////////////////////////////////////////////////////////////////////////
  sequence s_wakeReq; !rxAvailNOe && !rxAvailNIn && !remoteWake; endsequence
  sequence s_cfgWr; regWr && regAddr == `SWCFG_REG_CTRL && regWrData == 16'h0002; endsequence
  property p_rst; $rose(rst_b) |-> !enumReady && power_enable_n; endproperty
  property p_load; $rose(rst_b) |-> ##[1:12] enumReady; endproperty
  property p_susp; !rxAvailNOe [*2] |-> power_enable_n; endproperty
  property p_pull; !fifoPullDown; endproperty
  property p_wake; s_wakeReq |=> remoteWake; endproperty
  property p_wlen; $fell(remoteWake) |-> wakeCnt == WAKE_CYCLES; endproperty
  property p_cfg; s_cfgWr and enumReady |-> ##2 !power_enable_n; endproperty
  property p_ver; regRd && regAddr == `SWCFG_REG_USBVER |=> regRdData == 16'h0200; endproperty
  property p_pow; regRd && regAddr == `SWCFG_REG_MAXPOWER |=> regRdData == 16'h005A; endproperty
  a_rst: assert property (p_rst) else $error("outputs not idle after reset");
  a_load: assert property (p_load) else $error("config load late");
  a_susp: assert property (p_susp) else $error("power enable low in suspend");
  a_pull: assert property (p_pull) else $error("pull-down active");
  a_wake: assert property (p_wake) else $error("wake not taken");
  a_wlen: assert property (p_wlen) else $error("wake length wrong");
  a_cfg: assert property (p_cfg) else $error("power enable not low");
  a_ver: assert property (p_ver) else $error("usb version wrong");
  a_pow: assert property (p_pow) else $error("max power wrong");
endmodule // swcfg_monitor

// File: verif/swcfg_mcu_model.sv
`timescale 1ns/1ps
// Controller on the receive-available pin; the line has a pull-up
module swcfg_mcu_model (
  input  wire oe,
  input  wire devOut,
  input  wire wakeReq,
  output wire pinLevel
);
  // Never fights the device; strobes low only once the pin is released
  assign pinLevel = oe ? devOut : !wakeReq;
endmodule // swcfg_mcu_model

// File: verif/swcfg_suspend_wake_test.sv
`timescale 1ns/1ps
`include "swcfg_map.vh"
module swcfg_suspend_wake_test;
  localparam WK = 8;
  localparam [15:0] VC = 16'h0C3A;  // Arbitrary vendor code
  logic clk = 0, rst_b = 0, regWr = 0, regRd = 0, rxAvailNFifo = 1, wakeReq = 0;
  logic [7:0]  regAddr = 8'h00;
  logic [15:0] regWrData = 16'h0000;
  wire  [15:0] regRdData;
  wire rxAvailNIn, rxAvailNOut, rxAvailNOe, fifoPullDown, power_enable_n, enumReady, remoteWake;
  integer errors = 0, totalChecks = 0, n;
  initial forever #25 clk = ~clk;
  swcfg_suspend_wake #(.WAKE_CYCLES(WK), .VENDOR_CODE(VC)) swcfg_suspend_wake_i (.clk, .rst_b,
    .regAddr, .regWrData, .regWr, .regRd, .regRdData, .rxAvailNIn, .rxAvailNFifo, .rxAvailNOut,
    .rxAvailNOe, .fifoPullDown, .power_enable_n, .enumReady, .remoteWake);
  swcfg_mcu_model swcfg_mcu_model_i (.oe(rxAvailNOe), .devOut(rxAvailNOut), .wakeReq,
    .pinLevel(rxAvailNIn));
  ////////////////////////////////////////////////////////////////////////////////
  task chk(input [15:0] seen, input [15:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task edges(input integer k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task wr(input [7:0] a, input [15:0] d);
    @(posedge clk) begin regAddr <= a; regWrData <= d; regWr <= 1'b1; end
    @(posedge clk) regWr <= 1'b0;
  endtask
  task rd(input [7:0] a, input [15:0] e);
    @(posedge clk) begin regAddr <= a; regRd <= 1'b1; end
    @(posedge clk) regRd <= 1'b0;
    #1 chk(regRdData, e);
  endtask
  task tally_and_finish;
    if (errors == 0 && totalChecks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // Bounded wait: a load that never ends is a failure, not a hang
  task waitReady;
    // Looks 1 ns after each edge so the flag is settled when sampled
    for (n = 0; n < 50 && enumReady !== 1'b1; n++) edges(1);
    if (enumReady !== 1'b1) begin errors++; tally_and_finish; end
  endtask
  initial begin repeat (5000) @(posedge clk); errors++; tally_and_finish; end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    #1 chk(power_enable_n, 16'h0001);
    chk(rxAvailNOe, 16'h0001);
    waitReady;
    rd(`SWCFG_REG_MAXPOWER, 16'h005A);
    rd(`SWCFG_REG_USBVER, 16'h0200);
    rd(`SWCFG_REG_SERIAL, 16'h1234);
    rd(`SWCFG_REG_STATUS, 16'h0033);
    rd(`SWCFG_REG_VENDOR, VC);
    rd(8'h20, 16'h0000);
    // Flag passes through while awake, and a low flag then is no wake request
    @(posedge clk) rxAvailNFifo <= 1'b0;
    #1 chk(rxAvailNIn, 16'h0000);
    @(posedge clk) rxAvailNFifo <= 1'b1;
    #1 chk(remoteWake, 16'h0000);
    wr(`SWCFG_REG_CTRL, 16'h0002);
    edges(2);
    chk(power_enable_n, 16'h0000);
    wr(`SWCFG_REG_CTRL, 16'h0006);
    edges(1);
    chk(rxAvailNOe, 16'h0000);
    edges(1);
    chk(power_enable_n, 16'h0001);
    chk(fifoPullDown, 16'h0000);
    rd(`SWCFG_REG_CTRL, 16'h0006);
    @(posedge clk) wakeReq <= 1'b1;
    @(posedge clk) wakeReq <= 1'b0;
    #1 for (n = 0; remoteWake === 1'b1 && n < 20; n++) edges(1);
    chk(n, WK);
    edges(3);
    chk(rxAvailNOe, 16'h0001);
    chk(power_enable_n, 16'h0000);
    // USB reset reloads the store and drops the configured state
    wr(`SWCFG_REG_CTRL, 16'h0001);
    edges(2);
    chk(enumReady, 16'h0000);
    // Configuring while the reload runs is refused
    wr(`SWCFG_REG_CTRL, 16'h0002);
    waitReady;
    chk(power_enable_n, 16'h0001);
    rd(`SWCFG_REG_CTRL, 16'h0000);
    tally_and_finish;
  end
endmodule // swcfg_suspend_wake_test
bind swcfg_suspend_wake swcfg_monitor #(.WAKE_CYCLES(WAKE_CYCLES)) swcfg_monitor_i (.clk,
  .rst_b, .regAddr, .regWrData, .regWr, .regRd, .regRdData, .rxAvailNIn, .rxAvailNOe,
  .fifoPullDown, .power_enable_n, .enumReady, .remoteWake);
